// file: aasup_pkg.sv
`default_nettype none
package aasup_pkg;
    localparam int PIN_COUNT_DEF   = 8;
    localparam int PIN_SEL_W_DEF   = 3;
    localparam int MV_W_DEF        = 12;
    localparam logic [2:0] SWITCH_PIN_DEF = 3'h0;
    localparam logic [2:0] SHORT_PIN_DEF  = 3'h1;
    localparam logic       POL_ACTIVE_LOW_DEF  = 1'h1;
    localparam logic       POL_ACTIVE_HIGH_DEF = 1'h1;
    // Recovery waits this long after a short before powering up again.
    localparam int RECOVER_TIME_US = 1000;
    localparam int CLK_MHZ         = 100;
    localparam int RECOVER_CYCLES  = RECOVER_TIME_US * CLK_MHZ;

    typedef enum logic [1:0] {
        AASUP_ENG_EXTERNAL = 2'b00,
        AASUP_ENG_ADC      = 2'b01
    } aasup_engine_type;

    typedef enum logic [1:0] {
        AASUP_PWR_OFF     = 2'b00,
        AASUP_PWR_ON      = 2'b01,
        AASUP_PWR_UNKNOWN = 2'b10
    } aasup_power_type;

    typedef enum logic [2:0] {
        AASUP_ST_INIT     = 3'b000,
        AASUP_ST_DONTCARE = 3'b001,
        AASUP_ST_OK       = 3'b010,
        AASUP_ST_SHORT    = 3'b011,
        AASUP_ST_OPEN     = 3'b100
    } aasup_state_type;
endpackage
`default_nettype wire

// file: aasup_sense_if.sv
`timescale 1ns/1ps
`default_nettype none
interface aasup_sense_if;
    logic short_raw;
    logic open_raw;
    logic short_det;
    logic open_det;
    modport judge (input short_raw, input open_raw,
                   output short_det, output open_det);
    modport user  (output short_raw, output open_raw,
                   input short_det, input open_det);
endinterface
`default_nettype wire

// file: aasup_detect.sv
`timescale 1ns/1ps
`default_nettype none
module aasup_detect
    import aasup_pkg::*;
#(
    parameter int MV_W = MV_W_DEF
) (
    aasup_sense_if.judge                     sif,
    input  wire aasup_pkg::aasup_engine_type engine,
    input  wire logic                        short_detect_polarity,
    input  wire logic                        open_detect_polarity,
    input  wire logic [MV_W-1:0]             antenna_level_mv,
    input  wire logic [MV_W-1:0]             short_threshold_mv,
    input  wire logic [MV_W-1:0]             open_threshold_mv
);
    import aasup_pkg::*;

    wire logic is_adc;
    wire logic circ_short;
    wire logic circ_open;
    wire logic adc_short;
    wire logic adc_open;

    assign is_adc     = (engine == AASUP_ENG_ADC);
    // A polarity of one means the sense line is asserted when low.
    assign circ_short = short_detect_polarity ? ~sif.short_raw
                                              : sif.short_raw;
    assign circ_open  = open_detect_polarity ? ~sif.open_raw
                                             : sif.open_raw;
    // A shorted supply pulls the level down, an open one lets it rise.
    assign adc_short = antenna_level_mv <= short_threshold_mv;
    assign adc_open  = antenna_level_mv >= open_threshold_mv;
    assign sif.short_det = is_adc ? adc_short : circ_short;
    assign sif.open_det  = is_adc ? adc_open : circ_open;
endmodule
`default_nettype wire

// file: aasup_top.sv
`timescale 1ns/1ps
`default_nettype none
module aasup_top
    import aasup_pkg::*;
#(
    parameter int PIN_COUNT    = PIN_COUNT_DEF,
    parameter int PIN_SEL_W    = PIN_SEL_W_DEF,
    parameter int MV_W         = MV_W_DEF,
    parameter int RECOVER_CYC  = RECOVER_CYCLES
) (
    input  wire logic                        ref_clk,
    input  wire logic                        arst_n,
    input  wire logic                        supply_control_enable,
    input  wire logic                        short_detect_enable,
    input  wire logic                        short_detect_polarity,
    input  wire logic                        open_detect_enable,
    input  wire logic                        open_detect_polarity,
    input  wire logic                        power_down_on_short,
    input  wire logic                        power_down_polarity,
    input  wire logic                        auto_recovery_enable,
    input  wire logic                        power_save,
    input  wire logic [PIN_SEL_W-1:0]        supply_switch_pin_select,
    input  wire logic [PIN_SEL_W-1:0]        short_sense_pin_select,
    input  wire logic [MV_W-1:0]             short_threshold_mv,
    input  wire logic [MV_W-1:0]             open_threshold_mv,
    input  wire aasup_pkg::aasup_engine_type supervisor_engine_select,
    input  wire logic [MV_W-1:0]             antenna_level_mv,
    input  wire logic                        open_sense,
    input  wire logic [PIN_COUNT-1:0]        general_purpose_pin_in,
    output logic [PIN_COUNT-1:0]             general_purpose_pin_out,
    output logic [PIN_COUNT-1:0]             general_purpose_pin_oe,
    output aasup_pkg::aasup_state_type       supervision_state,
    output aasup_pkg::aasup_power_type       antenna_power_state,
    output logic                             status_notice
);
    import aasup_pkg::*;

    if (PIN_COUNT < 2 || (1 << PIN_SEL_W) < PIN_COUNT) begin : pin_sel_chk
        $error("aasup_top: pin select cannot address the pins");
    end
    if (RECOVER_CYC < 1) begin : rcv_cyc_chk
        $error("aasup_top: recovery count must be positive");
    end

    aasup_sense_if sif ();

    aasup_detect #(.MV_W(MV_W)) u_detect (
        .sif                   (sif.judge),
        .engine                (supervisor_engine_select),
        .short_detect_polarity (short_detect_polarity),
        .open_detect_polarity  (open_detect_polarity),
        .antenna_level_mv      (antenna_level_mv),
        .short_threshold_mv    (short_threshold_mv),
        .open_threshold_mv     (open_threshold_mv)
    );

    // The sense pin differs per board, so its index is a live input.
    assign sif.short_raw =
        general_purpose_pin_in[short_sense_pin_select];
    assign sif.open_raw  = open_sense;

    logic                   shut_r;
    logic                   shut_nxt;
    logic [31:0]            rcv_cnt_r;
    logic [31:0]            rcv_cnt_nxt;
    aasup_state_type        state_r;
    aasup_state_type        state_nxt;
    aasup_power_type        pwr_r;
    aasup_power_type        pwr_nxt;
    logic                   notice_r;
    logic [PIN_COUNT-1:0]   pin_out_r;
    logic [PIN_COUNT-1:0]   pin_oe_r;

    wire logic short_seen;
    wire logic open_seen;
    wire logic pdown_armed;
    wire logic rcv_armed;
    wire logic supply_on;
    wire logic ctrl_level;
    wire logic changed;

    assign short_seen  = short_detect_enable & sif.short_det;
    assign open_seen   = open_detect_enable & sif.open_det;
    assign pdown_armed = power_down_on_short & supply_control_enable
                       & short_detect_enable;
    assign rcv_armed   = auto_recovery_enable & pdown_armed;
    // Power save drops the supply; the receiver needs no antenna then.
    assign supply_on   = ~power_save & ~shut_r;
    // The pin carries power-down: asserted when supply is to be off.
    assign ctrl_level  = power_down_polarity ? ~supply_on : supply_on;

    always_comb begin
        shut_nxt    = shut_r;
        rcv_cnt_nxt = rcv_cnt_r;
        if (!pdown_armed) begin
            shut_nxt    = 1'b0;
            rcv_cnt_nxt = '0;
        end else if (!shut_r) begin
            shut_nxt    = short_seen;
            rcv_cnt_nxt = '0;
        end else if (rcv_armed) begin
            // The short cannot be sensed while unpowered, so retry by time.
            if (rcv_cnt_r >= 32'(RECOVER_CYC - 1)) begin
                shut_nxt    = 1'b0;
                rcv_cnt_nxt = '0;
            end else begin
                rcv_cnt_nxt = rcv_cnt_r + 32'h00000001;
            end
        end
    end

    always_comb begin
        if (!supply_control_enable && !short_detect_enable
                && !open_detect_enable)
            state_nxt = AASUP_ST_DONTCARE;
        else if (short_seen || shut_r)
            state_nxt = AASUP_ST_SHORT;
        else if (open_seen)
            state_nxt = AASUP_ST_OPEN;
        else
            state_nxt = AASUP_ST_OK;
        if (!supply_control_enable)
            pwr_nxt = AASUP_PWR_UNKNOWN;
        else if (supply_on)
            pwr_nxt = AASUP_PWR_ON;
        else
            pwr_nxt = AASUP_PWR_OFF;
    end

    assign changed = (state_nxt != state_r) || (pwr_nxt != pwr_r);

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            shut_r    <= 1'b0;
            rcv_cnt_r <= '0;
            state_r   <= AASUP_ST_INIT;
            pwr_r     <= AASUP_PWR_UNKNOWN;
            notice_r  <= 1'b0;
            pin_out_r <= '0;
            pin_oe_r  <= '0;
        end else begin
            shut_r    <= shut_nxt;
            rcv_cnt_r <= rcv_cnt_nxt;
            state_r   <= state_nxt;
            pwr_r     <= pwr_nxt;
            notice_r  <= changed;
            pin_out_r <= '0;
            pin_oe_r  <= '0;
            if (supply_control_enable) begin
                pin_out_r[supply_switch_pin_select] <= ctrl_level;
                pin_oe_r[supply_switch_pin_select]  <= 1'b1;
            end
        end
    end

    assign general_purpose_pin_out = pin_out_r;
    assign general_purpose_pin_oe  = pin_oe_r;
    assign supervision_state       = state_r;
    assign antenna_power_state     = pwr_r;
    assign status_notice           = notice_r;

    short_shut_a: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        pdown_armed && !shut_r && short_seen |=> shut_r)
        else $error("short did not remove supply");
    no_shut_a: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        !power_down_on_short |=> !shut_r)
        else $error("supply removed without power-down option");
    notice_change_a: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        status_notice == ($changed(supervision_state)
                          || $changed(antenna_power_state)))
        else $error("notice not tied to status change");
    pwr_unknown_a: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        !supply_control_enable |=> antenna_power_state == AASUP_PWR_UNKNOWN)
        else $error("power state not unknown");
    pin_drive_a: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        supply_control_enable |=> general_purpose_pin_oe
            == (PIN_COUNT'(1) << $past(supply_switch_pin_select)))
        else $error("switch pin not driven");
    oe_off_a: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        !supply_control_enable |=> general_purpose_pin_oe == '0)
        else $error("switch pin driven while control off");
    pd_pol_a: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        supply_control_enable && power_down_polarity && power_save |=>
        general_purpose_pin_out[$past(supply_switch_pin_select)])
        else $error("power-down level wrong");
    short_gate_a: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        supply_control_enable && !short_detect_enable && !shut_r
        && !open_seen |=> supervision_state == AASUP_ST_OK)
        else $error("short seen while detection off");
    open_flag_a: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        supply_control_enable && open_seen && !short_seen && !shut_r
        |=> supervision_state == AASUP_ST_OPEN)
        else $error("open not flagged");
    no_recover_a: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        shut_r && !auto_recovery_enable && pdown_armed |=> shut_r)
        else $error("recovered without auto recovery");
    rcv_time_a: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        shut_r && rcv_armed && rcv_cnt_r == 32'(RECOVER_CYC - 1)
        |=> !shut_r)
        else $error("supply not restored after recovery time");

    shut_c: cover property (@(posedge ref_clk) disable iff (!arst_n)
        !shut_r ##1 shut_r);
    recover_c: cover property (@(posedge ref_clk) disable iff (!arst_n)
        shut_r && rcv_armed ##1 !shut_r);
    open_c: cover property (@(posedge ref_clk) disable iff (!arst_n)
        supervision_state == AASUP_ST_OPEN);
    save_c: cover property (@(posedge ref_clk) disable iff (!arst_n)
        supply_control_enable && power_save);
    adc_short_c: cover property (@(posedge ref_clk) disable iff (!arst_n)
        supervisor_engine_select == AASUP_ENG_ADC && short_seen);
endmodule
`default_nettype wire

// file: aasup_antenna_model.sv
`timescale 1ns/1ps
`default_nettype none
module aasup_antenna_model #(
    parameter int PIN_COUNT = 8,
    parameter int PIN_SEL_W = 3
) (
    input  wire logic                 ref_clk,
    input  wire logic                 short_fault,
    input  wire logic                 open_fault,
    input  wire logic                 sense_active_low,
    input  wire logic [PIN_SEL_W-1:0] short_pin,
    input  wire logic [PIN_COUNT-1:0] pin_out,
    input  wire logic [PIN_COUNT-1:0] pin_oe,
    output logic      [PIN_COUNT-1:0] pin_in,
    output logic                      open_sense
);
    // Undriven pins other than the short sense pin toggle every cycle, so a wrong pin choice cannot pass.
    logic [PIN_COUNT-1:0] float_r = '0;
    logic [PIN_COUNT-1:0] sensed;
    always @(posedge ref_clk) begin
        float_r <= ~float_r;
    end
    always_comb begin
        sensed = float_r;
        sensed[short_pin] = short_fault ^ sense_active_low;
        pin_in = (pin_oe & pin_out) | (~pin_oe & sensed);
    end
    assign open_sense = open_fault ^ sense_active_low;
endmodule
`default_nettype wire

// file: tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import aasup_pkg::*;
    logic ref_clk = 0, arst_n = 0, sup_en = 0, sd_en = 0, sd_pol = 1;
    logic od_en = 0, od_pol = 1, pd_en = 0, pd_pol = 1, rec_en = 0;
    logic psave = 0, short_f = 0, open_f = 0, open_s;
    logic [2:0] sw_pin = 3'h2, sh_pin = 3'h5;
    logic [11:0] sh_thr = 12'h064, op_thr = 12'hBB8, level = 12'h7D0;
    aasup_engine_type eng = AASUP_ENG_EXTERNAL;
    logic [7:0] pin_in, pin_out, pin_oe;
    aasup_state_type st;
    aasup_power_type pwr;
    logic notice;
    int mismatches = 0, cmp_count = 0, cycles = 0;
    logic [11:0] lv [4] = '{12'h064, 12'h065, 12'hBB8, 12'hBB7};
    aasup_state_type ex [4] = '{AASUP_ST_SHORT, AASUP_ST_OK,
                                AASUP_ST_OPEN, AASUP_ST_OK};
    localparam int REC = 4;
    aasup_top #(.RECOVER_CYC(REC)) aasup_top_i (.ref_clk(ref_clk),
        .arst_n(arst_n), .supply_control_enable(sup_en),
        .short_detect_enable(sd_en), .short_detect_polarity(sd_pol),
        .open_detect_enable(od_en), .open_detect_polarity(od_pol),
        .power_down_on_short(pd_en), .power_down_polarity(pd_pol),
        .auto_recovery_enable(rec_en), .power_save(psave),
        .supply_switch_pin_select(sw_pin), .short_sense_pin_select(sh_pin),
        .short_threshold_mv(sh_thr), .open_threshold_mv(op_thr),
        .supervisor_engine_select(eng), .antenna_level_mv(level),
        .open_sense(open_s), .general_purpose_pin_in(pin_in),
        .general_purpose_pin_out(pin_out), .general_purpose_pin_oe(pin_oe),
        .supervision_state(st), .antenna_power_state(pwr),
        .status_notice(notice));
    aasup_antenna_model aasup_antenna_model_i (.ref_clk(ref_clk),
        .short_fault(short_f), .open_fault(open_f), .sense_active_low(1'h1),
        .short_pin(sh_pin), .pin_out(pin_out), .pin_oe(pin_oe),
        .pin_in(pin_in), .open_sense(open_s));
    always #5 ref_clk = ~ref_clk;
    task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            $display("Error %s expected %0h seen %0h", what, exp, seen);
            mismatches++;
        end
    endtask
    task automatic cyc(int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic results;
        $display("Checks %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic t_idle;
        chk("reset state", st, AASUP_ST_INIT);
        chk("reset power", pwr, AASUP_PWR_UNKNOWN);
        chk("reset oe", pin_oe, 8'h00);
        chk("reset notice", notice, 1'h0);
        @(negedge ref_clk) arst_n = 1;
        cyc(1);
        chk("idle state", st, AASUP_ST_DONTCARE);
        chk("idle notice", notice, 1'h1);
        cyc(1);
        chk("notice drop", notice, 1'h0);
    endtask
    task automatic t_supply;
        @(negedge ref_clk) sup_en = 1;
        cyc(1);
        chk("switch oe", pin_oe, 8'h04);
        chk("on pin", pin_out, 8'h00);
        chk("on power", pwr, AASUP_PWR_ON);
        chk("on notice", notice, 1'h1);
        @(negedge ref_clk) psave = 1;
        cyc(1);
        chk("save pin", pin_out, 8'h04);
        chk("save power", pwr, AASUP_PWR_OFF);
        @(negedge ref_clk) {psave, pd_pol, sw_pin} = {2'h0, 3'h6};
        cyc(1);
        chk("moved oe", pin_oe, 8'h40);
        chk("low pol pin", pin_out, 8'h40);
        @(negedge ref_clk) {pd_pol, sw_pin} = {1'h1, 3'h2};
        cyc(1);
        chk("back oe", pin_oe, 8'h04);
    endtask
    task automatic t_short;
        @(negedge ref_clk) {sd_en, short_f} = 2'h3;
        cyc(1);
        chk("short state", st, AASUP_ST_SHORT);
        chk("short notice", notice, 1'h1);
        chk("no pd power", pwr, AASUP_PWR_ON);
        @(negedge ref_clk) sd_pol = 0;
        cyc(1);
        chk("pol high", st, AASUP_ST_OK);
        @(negedge ref_clk) {sd_pol, sd_en} = 2'h2;
        cyc(1);
        chk("det off", st, AASUP_ST_OK);
        @(negedge ref_clk) {sd_en, pd_en} = 2'h3;
        cyc(2);
        chk("pd power", pwr, AASUP_PWR_OFF);
        chk("pd pin", pin_out, 8'h04);
        @(negedge ref_clk) short_f = 0;
        cyc(10);
        chk("no recover", pwr, AASUP_PWR_OFF);
        @(negedge ref_clk) rec_en = 1;
        cyc(REC);
        chk("recover wait", pwr, AASUP_PWR_OFF);
        cyc(1);
        chk("recovered", pwr, AASUP_PWR_ON);
        chk("rec pin", pin_out, 8'h00);
        chk("rec state", st, AASUP_ST_OK);
    endtask
    task automatic t_open;
        @(negedge ref_clk) {sd_en, pd_en, rec_en, od_en, open_f} = 5'h03;
        cyc(1);
        chk("open state", st, AASUP_ST_OPEN);
        @(negedge ref_clk) od_pol = 0;
        cyc(1);
        chk("open pol", st, AASUP_ST_OK);
        @(negedge ref_clk) {od_pol, sd_en, short_f} = 3'h7;
        cyc(1);
        chk("short first", st, AASUP_ST_SHORT);
        @(negedge ref_clk) {sd_en, short_f, od_en} = 3'h0;
        level = 12'h000;
        cyc(1);
        chk("open off", st, AASUP_ST_OK);
    endtask
    task automatic t_adc;
        @(negedge ref_clk) {open_f, sd_en, od_en} = 3'h3;
        eng = AASUP_ENG_ADC;
        level = 12'h7D0;
        cyc(1);
        chk("adc mid", st, AASUP_ST_OK);
        for (int i = 0; i < 4; i++) begin
            @(negedge ref_clk) level = lv[i];
            cyc(1);
            chk("adc state", st, ex[i]);
            chk("adc notice", notice, 1'h1);
        end
        cyc(1);
        chk("adc quiet", notice, 1'h0);
    endtask
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            results();
        end
    end
    initial begin
        cyc(12);
        t_idle();
        t_supply();
        t_short();
        t_open();
        t_adc();
        results();
    end
endmodule
`default_nettype wire
